// File: shared/pssr_pkg.sv
package pssr_pkg;
   // Register index (address bits 2:0 only)
   localparam logic [2:0] PSSR_ADDR_STATUS = 3'h2;
   localparam logic [2:0] PSSR_ADDR_FAULT = 3'h3;
   localparam logic [2:0] PSSR_ADDR_SHUNT = 3'h4;
   localparam logic [2:0] PSSR_ADDR_OUTV = 3'h5;
   localparam logic [2:0] PSSR_ADDR_AUX = 3'h6;
   localparam int PSSR_ADDR_USED = 3;
   // Status and fault bit positions
   localparam int PSSR_BIT_FET_ON = 7;
   localparam int PSSR_BIT_GPIO = 6;
   localparam int PSSR_BIT_SHORT = 5;
   localparam int PSSR_BIT_BOARD = 4;
   localparam int PSSR_BIT_PBAD = 3;
   localparam int PSSR_BIT_OC = 2;
   localparam int PSSR_BIT_UV = 1;
   localparam int PSSR_BIT_OV = 0;
   localparam logic [7:0] PSSR_FAULT_MASK = 8'h3F;
   // Reset values
   localparam logic [7:0] PSSR_FAULT_RST = 8'h00;
   localparam logic [7:0] PSSR_ADC_RST = 8'h00;
   // ADC channel codes from the conversion engine
   localparam logic [1:0] PSSR_CH_SHUNT = 2'h0;
   localparam logic [1:0] PSSR_CH_OUTV = 2'h1;
   localparam logic [1:0] PSSR_CH_AUX = 2'h2;
endpackage : pssr_pkg

// File: logic/pssr_fault_log.sv
`timescale 1ns/100ps
module pssr_fault_log
   import pssr_pkg::*;
#(
   parameter int WIDTH = 6
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [WIDTH-1:0] event_set,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WIDTH-1:0] flags
);
   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } pssr_flog_s;
   pssr_flog_s st_q, st_d;

   if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("pssr_fault_log: WIDTH out of range");
   end

   always_comb begin
      st_d = st_q;
      for (int i = 0; i < WIDTH; i++) begin
         if (event_set[i]) begin
            st_d.flags[i] = 1'b1;
         end else if (wr_en && !wr_data[i]) begin
            st_d.flags[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= '{flags: PSSR_FAULT_RST[WIDTH-1:0]};
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign flags = st_q.flags;
endmodule : pssr_fault_log

// File: logic/pssr_adc_reg.sv
`timescale 1ns/100ps
module pssr_adc_reg
   import pssr_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic test_mode,
   input wire logic conv_done,
   input wire logic [WIDTH-1:0] conv_data,
   input wire logic wr_en,
   input wire logic [WIDTH-1:0] wr_data,
   output logic [WIDTH-1:0] value
);
   typedef struct packed {
      logic [WIDTH-1:0] value;
   } pssr_adcr_s;
   pssr_adcr_s st_q, st_d;

   if (WIDTH != 8) begin : g_bad_width
      $error("pssr_adc_reg: WIDTH must be 8");
   end

   always_comb begin
      st_d = st_q;
      if (test_mode) begin
         if (wr_en) begin
            st_d.value = wr_data;
         end
      end else if (conv_done) begin
         st_d.value = conv_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= '{value: PSSR_ADC_RST[WIDTH-1:0]};
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign value = st_q.value;
endmodule : pssr_adc_reg

// File: logic/pssr_status_regs.sv
`timescale 1ns/100ps
// Behaviour
// - Status register at 02h is read only; writes change nothing.
// - Status bit 7 reads 1 while the FET is driven on.
// - Status bit 6 reflects the general purpose pin level.
// - Status bit 5 set while sense exceeds 2mV with FET commanded off.
// - Status bit 4 reads 1 while board presence input is low.
// - Status bit 3 reads 1 while output feedback input is low.
// - Status bit 2 reads 1 during overcurrent cool-down.
// - Status bit 1 reads 1 while low limit comparator is low.
// - Status bit 0 reads 1 while high limit comparator is high.
// - Fault bit 5 latches a detected FET short.
// - Fault bit 4 latches any board presence change.
// - Fault bit 3 latches output feedback going low.
// - Fault bit 2 latches an overcurrent fault.
// - Fault bit 1 latches low limit comparator going low.
// - Fault bit 0 latches high limit going high; bits 7:6 reserved.
// - Shunt result holds 8-bit sense conversion, 300uV per code.
// - Output voltage result holds 8-bit source conversion, 400mV per code.
// - Auxiliary result holds 8-bit aux conversion, 10mV per code.
// - ADC results writable only in test mode; test mode halts conversions.
// - Alert pulled low when a logged fault has its enable set.
// - Only register-address bits 2:0 are decoded.
module pssr_status_regs
   import pssr_pkg::*;
#(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_hit,
   input wire logic test_mode_control_bit,
   input wire logic [DATA_W-1:0] alert_enable,
   input wire logic fet_gate_on,
   input wire logic fet_on_cmd,
   input wire logic gpio_level,
   input wire logic sense_over_2mv,
   input wire logic board_presence_input,
   input wire logic output_feedback_input,
   input wire logic oc_cooldown,
   input wire logic oc_fault_event,
   input wire logic low_input_limit_comparator,
   input wire logic high_input_limit_comparator,
   input wire logic adc_done,
   input wire logic [1:0] adc_channel,
   input wire logic [DATA_W-1:0] adc_result,
   output logic adc_halt,
   output logic alert_n_oe
);
   typedef struct packed {
      logic [DATA_W-1:0] live_condition_flags;
      logic [DATA_W-1:0] rdata;
      logic hit;
      logic prev_valid;
      logic board_prev;
      logic fb_prev;
      logic uv_prev;
      logic ov_prev;
      logic alert_on;
   } pssr_top_s;
   pssr_top_s st_q, st_d;

   logic [5:0] fault_events;
   logic [5:0] fault_flags;
   logic [DATA_W-1:0] latched_event_log;
   logic [DATA_W-1:0] shunt_voltage_result;
   logic [DATA_W-1:0] output_voltage_result;
   logic [DATA_W-1:0] auxiliary_input_result;
   logic [DATA_W-1:0] live_d;
   logic [2:0] idx;
   logic wr_fault;
   logic short_now;
   localparam int N_ADC = 3;
   localparam logic [1:0] ADC_CH [N_ADC] = '{PSSR_CH_SHUNT, PSSR_CH_OUTV, PSSR_CH_AUX};
   localparam logic [2:0] ADC_ADDR [N_ADC] = '{PSSR_ADDR_SHUNT, PSSR_ADDR_OUTV, PSSR_ADDR_AUX};
   logic [DATA_W-1:0] adc_value [N_ADC];

   if (DATA_W != 8) begin : g_bad_data_w
      $error("pssr_status_regs: DATA_W must be 8");
   end
   if (ADDR_W < PSSR_ADDR_USED) begin : g_bad_addr_w
      $error("pssr_status_regs: ADDR_W too small");
   end

   assign idx = reg_addr[PSSR_ADDR_USED-1:0];
   assign wr_fault = reg_wr && (idx == PSSR_ADDR_FAULT);

   assign short_now = sense_over_2mv && !fet_on_cmd;

   always_comb begin
      live_d = '0;
      live_d[PSSR_BIT_FET_ON] = fet_gate_on;
      live_d[PSSR_BIT_GPIO] = gpio_level;
      live_d[PSSR_BIT_SHORT] = short_now;
      live_d[PSSR_BIT_BOARD] = !board_presence_input;
      live_d[PSSR_BIT_PBAD] = !output_feedback_input;
      live_d[PSSR_BIT_OC] = oc_cooldown;
      live_d[PSSR_BIT_UV] = !low_input_limit_comparator;
      live_d[PSSR_BIT_OV] = high_input_limit_comparator;
   end

   always_comb begin
      fault_events = '0;
      fault_events[PSSR_BIT_SHORT] = short_now;
      fault_events[PSSR_BIT_BOARD] = st_q.prev_valid &&
         (board_presence_input != st_q.board_prev);
      fault_events[PSSR_BIT_PBAD] = st_q.prev_valid && st_q.fb_prev &&
         !output_feedback_input;
      fault_events[PSSR_BIT_OC] = oc_fault_event;
      fault_events[PSSR_BIT_UV] = st_q.prev_valid && st_q.uv_prev &&
         !low_input_limit_comparator;
      fault_events[PSSR_BIT_OV] = st_q.prev_valid && !st_q.ov_prev &&
         high_input_limit_comparator;
   end

   pssr_fault_log #(
      .WIDTH(6)
   ) u_fault (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .event_set(fault_events),
      .wr_en(wr_fault),
      .wr_data(reg_wdata[5:0]),
      .flags(fault_flags)
   );
   assign latched_event_log = {2'h0, fault_flags} & PSSR_FAULT_MASK;

   assign adc_halt = test_mode_control_bit;

   for (genvar g = 0; g < N_ADC; g++) begin : g_adc
      pssr_adc_reg #(
         .WIDTH(DATA_W)
      ) u_res (
         .clk(clk),
         .rst_n(rst_n),
         .ce(ce),
         .test_mode(test_mode_control_bit),
         .conv_done(adc_done && (adc_channel == ADC_CH[g])),
         .conv_data(adc_result),
         .wr_en(reg_wr && (idx == ADC_ADDR[g])),
         .wr_data(reg_wdata),
         .value(adc_value[g])
      );
   end
   assign shunt_voltage_result = adc_value[0];
   assign output_voltage_result = adc_value[1];
   assign auxiliary_input_result = adc_value[2];

   always_comb begin
      st_d = st_q;
      st_d.live_condition_flags = live_d;
      st_d.prev_valid = 1'b1;
      st_d.board_prev = board_presence_input;
      st_d.fb_prev = output_feedback_input;
      st_d.uv_prev = low_input_limit_comparator;
      st_d.ov_prev = high_input_limit_comparator;
      st_d.alert_on = |(latched_event_log & alert_enable & PSSR_FAULT_MASK);
      st_d.hit = 1'b1;
      case (idx)
         PSSR_ADDR_STATUS: st_d.rdata = st_q.live_condition_flags;
         PSSR_ADDR_FAULT: st_d.rdata = latched_event_log;
         PSSR_ADDR_SHUNT: st_d.rdata = shunt_voltage_result;
         PSSR_ADDR_OUTV: st_d.rdata = output_voltage_result;
         PSSR_ADDR_AUX: st_d.rdata = auxiliary_input_result;
         default: begin
            // Control and alert registers live elsewhere
            st_d.rdata = '0;
            st_d.hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign reg_hit = st_q.hit;
   assign alert_n_oe = st_q.alert_on;
endmodule : pssr_status_regs

// File: testbench/pssr_chk.sv
`timescale 1ns/100ps
module pssr_chk
   import pssr_pkg::*;
#(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_hit,
   input wire logic test_mode_control_bit,
   input wire logic [DATA_W-1:0] alert_enable,
   input wire logic fet_on_cmd,
   input wire logic sense_over_2mv,
   input wire logic oc_fault_event,
   input wire logic adc_halt,
   input wire logic alert_n_oe
);
   default clocking cb @(posedge clk); endclocking
   // Frozen cycles are not judged
   default disable iff (!rst_n || !ce);
   logic [2:0] a;
   assign a = reg_addr[2:0];
   sequence s_at(logic [2:0] r);
      a == r;
   endsequence
   sequence s_short;
      sense_over_2mv && !fet_on_cmd;
   endsequence
   a_hit_decode: assert property (
      1 |=> reg_hit == ($past(a) inside {[3'h2:3'h6]})) else $error("hit wrong");
   a_unmap_zero: assert property (
      a inside {3'h0, 3'h1, 3'h7} |=> reg_rdata == '0) else $error("unmapped not zero");
   a_fault_rsvd: assert property (
      s_at(PSSR_ADDR_FAULT) |=> reg_rdata[7:6] == 2'h0) else $error("reserved set");
   a_short_live: assert property (
      s_short ##1 s_at(PSSR_ADDR_STATUS) |=> reg_rdata[PSSR_BIT_SHORT])
      else $error("short status missing");
   a_short_log: assert property (
      s_short ##1 s_at(PSSR_ADDR_FAULT) |=> reg_rdata[PSSR_BIT_SHORT])
      else $error("short fault missing");
   a_oc_log: assert property (
      oc_fault_event ##1 s_at(PSSR_ADDR_FAULT) |=> reg_rdata[PSSR_BIT_OC])
      else $error("overcurrent fault missing");
   a_alert_set: assert property (
      oc_fault_event && alert_enable[2] ##1 alert_enable[2] |=> alert_n_oe)
      else $error("alert not raised");
   a_alert_quiet: assert property (
      alert_enable[5:0] == 6'h00 |=> !alert_n_oe) else $error("alert while disabled");
   a_halt_mirror: assert property (
      adc_halt == test_mode_control_bit) else $error("halt not test mode");
endmodule : pssr_chk
bind pssr_status_regs pssr_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_chk (
   .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
   .reg_hit(reg_hit), .test_mode_control_bit(test_mode_control_bit),
   .alert_enable(alert_enable), .fet_on_cmd(fet_on_cmd), .sense_over_2mv(sense_over_2mv),
   .oc_fault_event(oc_fault_event), .adc_halt(adc_halt), .alert_n_oe(alert_n_oe));

// File: testbench/pssr_host_model.sv
`timescale 1ns/100ps
module pssr_host_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_hit
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      @(posedge clk);
      #1 reg_addr = adr;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1 reg_wr = 1'b0;
      // Stale data must not look valid
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] adr, output logic [7:0] d, output logic h);
      @(posedge clk);
      #1 reg_addr = adr;
      @(posedge clk);
      #1 d = reg_rdata;
      h = reg_hit;
   endtask : rd
endmodule : pssr_host_model

// File: testbench/test_power_switch_status_regs.sv
`timescale 1ns/100ps
module test_power_switch_status_regs
   import pssr_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic tm = 1'b0;
   logic [7:0] al_en = 8'h00;
   // Inputs: fet, gpio, sense, board, fb, cool, low, high, cmd, oc event
   logic [9:0] v = 10'h06A;
   logic done = 1'b0;
   logic [1:0] ch = 2'h0;
   logic [7:0] res = 8'h00;
   wire logic [7:0] addr, wdata, rdata;
   wire logic wr, hit, halt, alert;
   logic [7:0] d;
   logic h;
   int n_errors = 0;
   int compares = 0;
   always #20 clk = ~clk;
   pssr_status_regs #(.DATA_W(8), .ADDR_W(8)) i_dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rdata(rdata), .reg_hit(hit), .test_mode_control_bit(tm), .alert_enable(al_en),
      .fet_gate_on(v[9]), .fet_on_cmd(v[1]), .gpio_level(v[8]), .sense_over_2mv(v[7]),
      .board_presence_input(v[6]), .output_feedback_input(v[5]), .oc_cooldown(v[4]),
      .oc_fault_event(v[0]), .low_input_limit_comparator(v[3]),
      .high_input_limit_comparator(v[2]), .adc_done(done), .adc_channel(ch),
      .adc_result(res), .adc_halt(halt), .alert_n_oe(alert));
   pssr_host_model i_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rdata(rdata), .reg_hit(hit));
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic finish_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic step(input logic [9:0] nv);
      @(posedge clk);
      #1 v = nv;
   endtask : step
   task automatic conv(input logic [1:0] c, input logic [7:0] x);
      @(posedge clk);
      #1 done = 1'b1;
      ch = c;
      res = x;
      @(posedge clk);
      #1 done = 1'b0;
      res = ~x;
   endtask : conv
   function automatic logic [7:0] exp_st(input logic [9:0] x);
      return {x[9], x[8], x[7] & ~x[1], ~x[6], ~x[5], x[4], ~x[3], x[2]};
   endfunction : exp_st
   task automatic t_status();
      logic [9:0] pat [3] = '{10'h2AA, 10'h155, 10'h0A4};
      foreach (pat[i]) begin
         step(pat[i]);
         i_host.rd(8'hFA, d, h);
         chk("status", d, exp_st(pat[i]));
         chk("status hit", {7'h00, h}, 8'h01);
         i_host.wr(8'h02, ~d);
         i_host.rd(8'h02, d, h);
         chk("status after write", d, exp_st(pat[i]));
      end
   endtask : t_status
   task automatic t_faults();
      step(10'h06A);
      i_host.wr(8'h03, 8'h00);
      i_host.rd(8'h03, d, h);
      chk("fault clear", d, 8'h00);
      al_en = 8'h04;
      step(10'h06B);
      step(10'h06A);
      i_host.rd(8'h03, d, h);
      chk("oc fault", d, 8'h04);
      chk("alert", {7'h00, alert}, 8'h01);
      step(10'h084);
      i_host.rd(8'h03, d, h);
      chk("all faults", d, 8'h3F);
      step(10'h06A);
      // Overcurrent is high only at the edge that takes the clearing write
      fork
         i_host.wr(8'h03, 8'h00);
         begin
            step(10'h06B);
            step(10'h06A);
         end
      join
      i_host.rd(8'h03, d, h);
      chk("set beats clear", d, 8'h04);
      al_en = 8'h00;
      i_host.wr(8'h03, 8'h00);
      i_host.rd(8'h03, d, h);
      chk("cleared", d, 8'h00);
      chk("alert off", {7'h00, alert}, 8'h00);
   endtask : t_faults
   task automatic t_adc();
      logic [7:0] pat [3] = '{8'h5A, 8'hA5, 8'hFF};
      foreach (pat[i]) conv(2'(i), pat[i]);
      foreach (pat[i]) begin
         i_host.rd(8'h04 + 8'(i), d, h);
         chk("adc result", d, pat[i]);
      end
      i_host.wr(8'h04, 8'h11);
      i_host.rd(8'h04, d, h);
      chk("adc locked", d, 8'h5A);
      tm = 1'b1;
      i_host.wr(8'h05, 8'h3C);
      conv(2'h1, 8'h00);
      i_host.rd(8'h05, d, h);
      chk("adc test write", d, 8'h3C);
      chk("halt", {7'h00, halt}, 8'h01);
      tm = 1'b0;
   endtask : t_adc
   task automatic t_freeze();
      chk("halt off", {7'h00, halt}, 8'h00);
      al_en = 8'h04;
      step(10'h06B);
      step(10'h06A);
      i_host.rd(8'h03, d, h);
      chk("oc before freeze", d, 8'h04);
      @(posedge clk);
      #1 ce = 1'b0;
      i_host.wr(8'h03, 8'h00);
      conv(2'h0, 8'h00);
      i_host.rd(8'h04, d, h);
      chk("frozen read", d, 8'h04);
      @(posedge clk);
      #1 ce = 1'b1;
      i_host.rd(8'h03, d, h);
      chk("log kept", d, 8'h04);
      i_host.rd(8'h04, d, h);
      chk("result kept", d, 8'h5A);
   endtask : t_freeze
   task automatic t_reset();
      @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("reset rdata", rdata, 8'h00);
      chk("reset hit", {7'h00, hit}, 8'h00);
      chk("reset alert", {7'h00, alert}, 8'h00);
      i_host.rd(8'h03, d, h);
      chk("reset log", d, 8'h00);
      i_host.rd(8'h06, d, h);
      chk("reset result", d, 8'h00);
      al_en = 8'h00;
   endtask : t_reset
   task automatic t_unmapped();
      logic [7:0] ad [4] = '{8'h00, 8'h01, 8'h07, 8'hF9};
      foreach (ad[i]) begin
         i_host.rd(ad[i], d, h);
         chk("unmapped", d, 8'h00);
         chk("unmapped hit", {7'h00, h}, 8'h00);
      end
   endtask : t_unmapped
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      t_status();
      t_faults();
      t_adc();
      t_freeze();
      t_reset();
      t_unmapped();
      finish_test();
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      finish_test();
   end
endmodule : test_power_switch_status_regs
